// [sim/cbt_host_model.sv]
/*
 Host memory bus model: completes a shared cycle a set number of cycles after a request.
 Assumes host_req is a level that drops after host_done is seen.
*/
`timescale 1ns/1ns

module cbt_host_model
   import cbt_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Shared cycle
   input  wire logic       host_req,
   input  wire logic [3:0] lat,
   output logic            host_done
);
   logic [3:0] cnt_ff;
   logic       served_ff;

   // Host serves one shared cycle per request
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_ff    <= 4'h0;
         served_ff <= 1'b0;
         host_done <= 1'b0;
      end
      else
      begin
         host_done <= 1'b0;
         if (!host_req)
         begin
            cnt_ff    <= 4'h0;
            served_ff <= 1'b0;
         end
         else if (!served_ff && cnt_ff == lat)
         begin
            host_done <= 1'b1;
            served_ff <= 1'b1;
         end
         else if (!served_ff)
            cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule // cbt_host_model

// [sim/tb.sv]
/*
 Testbench of the coprocessor bus glue: register access, decode, mapping and timeout.
 Assumes pull-ups on the open lines and a reduced watchdog divider.
*/
`timescale 1ns/1ns

module tb;
   import cbt_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0]  bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, host_req, host_slow, host_done;
   logic rom_sel_n, ram_sel_n, region_n, iack_n, wdo, periph_clk;
   logic [14:0] rom_addr;
   logic [12:0] ram_addr;
   logic [15:0] host_addr;
   logic [3:0]  lat = 4'h3;
   logic        en = 1'b1;
   logic [3:0]  wv;
   cbt_cpu_t    cpu_bus = '1;
   cbt_cpu_t    exp_bus;
   cbt_od_t     od_in, od_out, od_oe;
   int          cyc = 0, n_mismatch = 0, n_tests = 0;

   assign od_in = cbt_od_t'(~od_oe);
   assign periph_clk = cyc[2];
   assign wv = {host_req, wdo, od_oe.fault, od_oe.ack};

   cbt_glue #(.WD_DIV(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .aclk_en(en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cpu_bus(cpu_bus), .periph_clk(periph_clk), .od_in(od_in), .od_out(od_out),
      .od_oe(od_oe), .rom_sel_n(rom_sel_n), .rom_addr(rom_addr), .ram_sel_n(ram_sel_n),
      .ram_addr(ram_addr), .host_req(host_req), .host_addr(host_addr),
      .host_slow(host_slow), .host_done(host_done), .exp_bus(exp_bus),
      .expansion_region_sel_n(region_n), .irq_ack_strobe_n(iack_n), .watchdog_out(wdo));

   cbt_host_model u_host (.aclk(aclk), .aresetn(aresetn), .host_req(host_req), .lat(lat),
      .host_done(host_done));

   initial
   begin
      forever #50 aclk = ~aclk;
   end

   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic haw, hw, hb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(negedge aclk);
         haw = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (haw) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      chk(r, er);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ha, hr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(negedge aclk);
         ha = arvalid & arready;
         hr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) break;
      end
      rready <= 1'b0;
      chk(d, ed);
      chk(r, er);
   endtask

   task automatic acc(input logic [19:0] a);
      @(posedge aclk);
      cpu_bus.addr <= a;
      cpu_bus.addr_strobe_n <= 1'b0;
      cpu_bus.data_strobe_n <= 1'b0;
   endtask

   task automatic rel();
      @(posedge aclk);
      cpu_bus.addr_strobe_n <= 1'b1;
      cpu_bus.data_strobe_n <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask

   // Wait up to lim cycles for a watched output, then compare
   task automatic wait_hi(input int i, input int lim, input logic e);
      for (int k = 0; k < lim && wv[i] !== 1'b1; k++)
         @(negedge aclk);
      chk(wv[i], e);
   endtask

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h000, 32'h2e, 2'b00);
      rd(12'h00c, 32'h0, 2'b10);
      wr(12'h00c, 32'h5, 2'b10);
      wr(12'h004, 32'h15, 2'b00);
      rd(12'h004, 32'h15, 2'b00);
      chk(od_oe, 32'h15);
      rd(12'h008, 32'h006a_0000, 2'b00);
      wr(12'h004, 32'h0, 2'b00);
      for (int f = 0; f < 8; f++)
      begin
         @(posedge aclk);
         cpu_bus[2:0] <= f[2:0];
         repeat (2) @(negedge aclk);
         chk(iack_n, {31'h0, f != 7});
      end
      acc(20'he1234);
      repeat (2) @(negedge aclk);
      chk(region_n, 0);
      chk(exp_bus[33:2], cpu_bus[33:2]);
      chk(exp_bus[1:0], cpu_bus[1:0]);
      wait_hi(1, 20, 0);
      wait_hi(1, 200, 1);
      chk(wdo, 1);
      chk(od_out, 0);
      rel();
      chk(wv[1], 0);
      chk(region_n, 1);
      wr(12'h000, 32'h2c, 2'b00);
      acc(20'he0000);
      wait_hi(2, 200, 1);
      chk(wv[1], 0);
      rel();
      wr(12'h000, 32'h2e, 2'b00);
      acc(20'h00008);
      wait_hi(3, 5, 1);
      chk(host_addr, 16'h0808);
      chk(host_slow, 1);
      wait_hi(0, 20, 1);
      rel();
      acc(20'h02abc);
      wait_hi(0, 20, 1);
      chk(host_addr, 16'h2abc);
      rel();
      acc(20'h0080b);
      wait_hi(0, 20, 1);
      chk(host_addr, 16'h000b);
      rel();
      acc(20'h1f004);
      wait_hi(0, 5, 1);
      chk(ram_sel_n, 0);
      chk(host_slow, 0);
      rel();
      acc(20'h17ffe);
      wait_hi(0, 5, 1);
      chk(rom_sel_n, 0);
      rel();
      wr(12'h000, 32'h56, 2'b00);
      acc(20'h19800);
      wait_hi(0, 5, 1);
      chk(ram_addr, 13'h1800);
      rel();
      acc(20'h16abc);
      wait_hi(0, 5, 1);
      chk(rom_addr, 15'h6abc);
      rel();
      wr(12'h000, 32'h2f, 2'b00);
      acc(20'h00100);
      wait_hi(3, 20, 0);
      rel();
      wr(12'h000, 32'h2a, 2'b00);
      acc(20'h00004);
      wait_hi(0, 5, 1);
      chk(rom_sel_n, 0);
      rel();
      lat <= 4'h0;
      acc(20'h10004);
      wait_hi(3, 5, 1);
      chk(host_addr, 16'h0004);
      wait_hi(0, 20, 1);
      rel();
      // Internal tick with the clock enable frozen for a while
      wr(12'h000, 32'hae, 2'b00);
      acc(20'he0000);
      @(posedge aclk);
      en <= 1'b0;
      wait_hi(1, 40, 0);
      @(posedge aclk);
      en <= 1'b1;
      wait_hi(1, 12, 0);
      wait_hi(1, 30, 1);
      rel();
      tally_and_finish();
   end
endmodule // tb

// [verilog/cbt_defines.svh]
/*
 Offsets, reset values, field positions and timing counts of the coprocessor bus glue.
 Assumes a 10 MHz aclk and a 12-bit AXI4-Lite byte address.
*/
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// Register byte offsets
`define CBT_OFF_CTRL     12'h000
`define CBT_OFF_FORCE    12'h004
`define CBT_OFF_STATUS   12'h008

// Reset values
`define CBT_CTRL_RST     8'h2e
`define CBT_FORCE_RST    5'h00

// Status field positions
`define CBT_ST_CNT_LSB   0
`define CBT_ST_FAULT     9
`define CBT_ST_HOST      10
`define CBT_ST_LINE_LSB  16

// Address regions, top nibble of the coprocessor address
`define CBT_SEG_LOW      4'h0
`define CBT_SEG_BOARD    4'h1
`define CBT_SEG_EXP      4'he

// Timing
`define CBT_CLK_NS       100
`define CBT_TIMEOUT_NS   180000
`define CBT_TIMEOUT_CYC  (`CBT_TIMEOUT_NS / `CBT_CLK_NS)
`define CBT_WD_DIV       256
`define CBT_TICK_CYC     (`CBT_TIMEOUT_CYC / `CBT_WD_DIV)

`endif

// [verilog/cbt_glue.sv]
/*
 Coprocessor card glue: bus timeout, memory mapping, region and strobe decode,
 open-collector drivers and an AXI4-Lite register slave for the settings.
 Assumes all pins synchronous to aclk and an external pull-up on every open line.
*/
`timescale 1ns/1ns
`include "cbt_defines.svh"

// What this block does
// - Unanswered access for 180 us raises bus fault
// - Timeout is divide-by-256 slow-clock counter, output exposed
// - Acknowledge going high clears the counter
// - Fault reaches processor only with timeout enabled
// - Service setting blocks all host memory accesses
// - Alternate map: ROM low, host at 10000
// - Region select low for E0000-EFFFF with strobe
// - Interrupt acknowledge is NAND of function codes
// - Host slowed while host region (low 64K in normal map, 10000 in alternate) accessed
// - Host full speed for other accesses
// - Bus error vector 00008 reached at host 808 in normal map
// - Processor inputs driven only by pull-downs
// - Large RAM link widens RAM decode
// - Large ROM link widens ROM decode
// - Expansion port carries address, data and control
// - Normal map swaps host pages 0-3 with 8-B
// - Normal map: ROM 10000, RAM 18000, repeating
module cbt_glue
   import cbt_pkg::*;
#(
   parameter int ADDR_W   = 12,
   parameter int WD_DIV   = `CBT_WD_DIV,
   parameter int TICK_CYC = `CBT_TICK_CYC
)
(
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                aclk_en,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Coprocessor bus
   input  wire cbt_cpu_t            cpu_bus,
   input  wire logic                periph_clk,
   input  wire cbt_od_t             od_in,
   output cbt_od_t                  od_out,
   output cbt_od_t                  od_oe,
   // Onboard memory
   output logic                     rom_sel_n,
   output logic [14:0]              rom_addr,
   output logic                     ram_sel_n,
   output logic [12:0]              ram_addr,
   // Host memory bus
   output logic                     host_req,
   output logic [15:0]              host_addr,
   output logic                     host_slow,
   input  wire logic                host_done,
   // Expansion connector
   output cbt_cpu_t                 exp_bus,
   output logic                     expansion_region_sel_n,
   output logic                     irq_ack_strobe_n,
   output logic                     watchdog_out
);

   localparam int CW = $clog2(WD_DIV+1);
   localparam int TW = $clog2(TICK_CYC+1);

   localparam logic [ADDR_W-3:0] IX_CTRL   = (ADDR_W-2)'(`CBT_OFF_CTRL >> 2);
   localparam logic [ADDR_W-3:0] IX_FORCE  = (ADDR_W-2)'(`CBT_OFF_FORCE >> 2);
   localparam logic [ADDR_W-3:0] IX_STATUS = (ADDR_W-2)'(`CBT_OFF_STATUS >> 2);

   if (ADDR_W < 4 || TICK_CYC < 1 || WD_DIV > 511)
   begin : g_bad_param
      $error("cbt_glue: ADDR_W, TICK_CYC or WD_DIV out of range");
   end

   // Low-page swap seen from the host side
   function automatic logic [15:0] swap_low_pages(input logic [15:0] a);
      swap_low_pages = a;
      if (a[15:12] == 4'h0 && a[10] == 1'b0)
         swap_low_pages[11] = ~a[11];
   endfunction

   function automatic logic [31:0] merge_low(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
      merge_low = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            merge_low[8*i +: 8] = wd[8*i +: 8];
   endfunction

   // Register state
   cbt_ctrl_t       ctrl_ff;
   logic [4:0]      force_ff;
   logic            aw_got_ff;
   logic            w_got_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [31:0]     w_data_ff;
   logic [3:0]      w_strb_ff;
   cbt_rd_state_t   rd_state_ff;

   // Bus state
   logic            fault_ff;
   logic            ack_prev_ff;
   logic            pclk_prev_ff;
   logic [TW-1:0]   tick_cnt_ff;
   logic            local_ack_ff;
   logic            host_ack_ff;
   logic [CW-1:0]   wd_count;
   logic            wd_term;

   logic [3:0]      seg;
   logic            strobe;
   logic            host_hit;
   logic            rom_hit;
   logic            ram_hit;
   logic            tick;
   logic            ack_rise;
   logic            do_write;
   logic [31:0]     cur_word;

   assign seg    = cpu_bus.addr[19:16];
   assign strobe = !cpu_bus.addr_strobe_n;

   // Region decode
   assign host_hit = ctrl_ff.map_normal ? (seg == `CBT_SEG_LOW)
                                        : (seg == `CBT_SEG_BOARD);
   assign rom_hit  = ctrl_ff.map_normal ? (seg == `CBT_SEG_BOARD && !cpu_bus.addr[15])
                                        : (seg == `CBT_SEG_LOW);
   assign ram_hit  = ctrl_ff.map_normal && seg == `CBT_SEG_BOARD && cpu_bus.addr[15];

   // Slow clock edge and acknowledge release
   assign ack_rise = od_in.ack && !ack_prev_ff;
   assign tick     = ctrl_ff.int_tick ? (tick_cnt_ff == TW'(TICK_CYC - 1))
                                      : (periph_clk && !pclk_prev_ff);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ack_prev_ff  <= 1'b1;
         pclk_prev_ff <= 1'b0;
         tick_cnt_ff  <= '0;
      end
      else if (aclk_en)
      begin
         ack_prev_ff  <= od_in.ack;
         pclk_prev_ff <= periph_clk;
         if (tick_cnt_ff == TW'(TICK_CYC - 1))
            tick_cnt_ff <= '0;
         else
            tick_cnt_ff <= tick_cnt_ff + TW'(1);
      end
   end

   cbt_watchdog #(
      .DIV      (WD_DIV)
   ) u_wd (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .aclk_en  (aclk_en),
      .strobe   (strobe),
      .tick     (tick),
      .ack_rise (ack_rise),
      .count_ff (wd_count),
      .terminal (wd_term)
   );

   // Bus fault, held until the strobe goes away
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fault_ff <= 1'b0;
      else if (aclk_en)
      begin
         if (!strobe)
            fault_ff <= 1'b0;
         else if (wd_term && ctrl_ff.timeout_en)
            fault_ff <= 1'b1;
      end
   end

   // Local and host acknowledge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         local_ack_ff <= 1'b0;
         host_ack_ff  <= 1'b0;
         host_req     <= 1'b0;
      end
      else if (aclk_en)
      begin
         local_ack_ff <= strobe && (rom_hit || ram_hit);
         if (!strobe)
            host_ack_ff <= 1'b0;
         else if (host_req && host_done)
            host_ack_ff <= 1'b1;
         host_req <= strobe && host_hit && !ctrl_ff.service_block
                     && !host_ack_ff && !(host_req && host_done);
      end
   end

   assign host_slow = host_req;

   // Memory selects and addresses
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rom_sel_n <= 1'b1;
         ram_sel_n <= 1'b1;
         rom_addr  <= '0;
         ram_addr  <= '0;
         host_addr <= '0;
      end
      else if (aclk_en)
      begin
         rom_sel_n <= !(strobe && rom_hit);
         ram_sel_n <= !(strobe && ram_hit);
         rom_addr  <= {cpu_bus.addr[14] && ctrl_ff.large_rom_link && !ctrl_ff.small_rom_link,
                       cpu_bus.addr[13:0]};
         ram_addr  <= {cpu_bus.addr[12:11] & {2{ctrl_ff.large_ram_link
                                                 && !ctrl_ff.small_ram_link}},
                       cpu_bus.addr[10:0]};
         host_addr <= ctrl_ff.map_normal ? swap_low_pages(cpu_bus.addr[15:0])
                                         : cpu_bus.addr[15:0];
      end
   end

   // Expansion connector
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         exp_bus                <= '1;
         expansion_region_sel_n <= 1'b1;
         irq_ack_strobe_n       <= 1'b1;
         watchdog_out           <= 1'b0;
      end
      else if (aclk_en)
      begin
         exp_bus                <= cpu_bus;
         expansion_region_sel_n <= !(strobe && seg == `CBT_SEG_EXP);
         irq_ack_strobe_n       <= !(cpu_bus.function_code_0 && cpu_bus.function_code_1
                                     && cpu_bus.function_code_2);
         watchdog_out           <= wd_term;
      end
   end

   // Open-collector drivers
   assign od_out = '0;
   assign od_oe  = '{ack:   local_ack_ff || host_ack_ff,
                     fault: fault_ff,
                     halt:  force_ff[4],
                     rst:   force_ff[3],
                     vpa:   force_ff[2],
                     irq_b: force_ff[1],
                     irq_a: force_ff[0]};

   // AXI4-Lite write path
   assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
   assign do_write      = aw_got_ff && w_got_ff && !s_axi_bvalid;

   always_comb
   begin
      cur_word = 32'h0000_0000;
      if (aw_addr_ff[ADDR_W-1:2] == IX_CTRL)
         cur_word = {24'h00_0000, ctrl_ff};
      else if (aw_addr_ff[ADDR_W-1:2] == IX_FORCE)
         cur_word = {27'h000_0000, force_ff};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_ff    <= 1'b0;
         w_got_ff     <= 1'b0;
         aw_addr_ff   <= '0;
         w_data_ff    <= '0;
         w_strb_ff    <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else if (aclk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_ff  <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_ff[ADDR_W-1:2] == IX_CTRL ||
                             aw_addr_ff[ADDR_W-1:2] == IX_FORCE ||
                             aw_addr_ff[ADDR_W-1:2] == IX_STATUS)
                            ? 2'b00 : 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Settings registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_ff  <= `CBT_CTRL_RST;
         force_ff <= `CBT_FORCE_RST;
      end
      else if (aclk_en && do_write)
      begin
         if (aw_addr_ff[ADDR_W-1:2] == IX_CTRL)
            ctrl_ff <= cbt_ctrl_t'(8'(merge_low(cur_word, w_data_ff, w_strb_ff)));
         if (aw_addr_ff[ADDR_W-1:2] == IX_FORCE)
            force_ff <= 5'(merge_low(cur_word, w_data_ff, w_strb_ff));
      end
   end

   // AXI4-Lite read path
   assign s_axi_arready = (rd_state_ff == CBT_RD_IDLE);
   assign s_axi_rvalid  = (rd_state_ff == CBT_RD_RESP);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_ff <= CBT_RD_IDLE;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'b00;
      end
      else if (aclk_en)
      begin
         case (rd_state_ff)
            CBT_RD_IDLE:
            begin
               if (s_axi_arvalid)
               begin
                  rd_state_ff <= CBT_RD_RESP;
                  s_axi_rresp <= 2'b00;
                  s_axi_rdata <= 32'h0000_0000;
                  if (s_axi_araddr[ADDR_W-1:2] == IX_CTRL)
                     s_axi_rdata <= {24'h00_0000, ctrl_ff};
                  else if (s_axi_araddr[ADDR_W-1:2] == IX_FORCE)
                     s_axi_rdata <= {27'h000_0000, force_ff};
                  else if (s_axi_araddr[ADDR_W-1:2] == IX_STATUS)
                  begin
                     s_axi_rdata[`CBT_ST_CNT_LSB +: CW] <= wd_count;
                     s_axi_rdata[`CBT_ST_FAULT]         <= fault_ff;
                     s_axi_rdata[`CBT_ST_HOST]          <= host_req;
                     s_axi_rdata[`CBT_ST_LINE_LSB +: 7] <= od_in;
                  end
                  else
                     s_axi_rresp <= 2'b10;
               end
            end
            CBT_RD_RESP:
            begin
               if (s_axi_rready)
                  rd_state_ff <= CBT_RD_IDLE;
            end
            default:
               rd_state_ff <= CBT_RD_IDLE;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_fault_cause;
      $rose(fault_ff) |-> $past(wd_term) && $past(strobe) && $past(ctrl_ff.timeout_en);
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("fault without timeout");

   property p_fault_disabled;
      !ctrl_ff.timeout_en && !fault_ff && aclk_en |=> !od_oe.fault;
   endproperty
   a_fault_disabled: assert property (p_fault_disabled) else $error("fault while disabled");

   property p_service_block;
      ctrl_ff.service_block && aclk_en |=> !host_req;
   endproperty
   a_service_block: assert property (p_service_block) else $error("host access not blocked");

   property p_alt_rom;
      aclk_en && strobe && !ctrl_ff.map_normal && seg == `CBT_SEG_LOW |=> !rom_sel_n;
   endproperty
   a_alt_rom: assert property (p_alt_rom) else $error("ROM not low in alternate map");

   property p_region_sel;
      aclk_en |=> expansion_region_sel_n == !($past(strobe) && $past(seg) == `CBT_SEG_EXP);
   endproperty
   a_region_sel: assert property (p_region_sel) else $error("region select wrong");

   property p_irq_ack;
      aclk_en |=> irq_ack_strobe_n == !($past(cpu_bus.function_code_0)
                  && $past(cpu_bus.function_code_1) && $past(cpu_bus.function_code_2));
   endproperty
   a_irq_ack: assert property (p_irq_ack) else $error("interrupt acknowledge wrong");

   property p_vector_swap;
      aclk_en && ctrl_ff.map_normal && cpu_bus.addr == 20'h0_0008 |=> host_addr == 16'h0808;
   endproperty
   a_vector_swap: assert property (p_vector_swap) else $error("vector page not swapped");

   property p_pulldown_only;
      od_out == '0;
   endproperty
   a_pulldown_only: assert property (p_pulldown_only) else $error("open line driven high");

   property p_fault_hold;
      aclk_en && fault_ff && strobe |=> fault_ff;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped during access");

   property p_local_ack;
      aclk_en && strobe && ram_hit |=> od_oe.ack;
   endproperty
   a_local_ack: assert property (p_local_ack) else $error("onboard access not acknowledged");

   c_fault:     cover property (aclk_en && $rose(fault_ff));
   c_host_done: cover property (host_req && host_done);
   c_rom_read:  cover property (!rom_sel_n && od_oe.ack);

endmodule // cbt_glue

// [verilog/cbt_pkg.sv]
/*
 Types shared by the coprocessor bus glue.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cbt_pkg;

   // Open-collector lines of the processor
   typedef struct packed {
      logic ack;
      logic fault;
      logic halt;
      logic rst;
      logic vpa;
      logic irq_b;
      logic irq_a;
   } cbt_od_t;

   // Jumper and link settings
   typedef struct packed {
      logic int_tick;
      logic large_rom_link;
      logic small_rom_link;
      logic large_ram_link;
      logic small_ram_link;
      logic map_normal;
      logic timeout_en;
      logic service_block;
   } cbt_ctrl_t;

   // Coprocessor bus as seen on the expansion connector
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  data;
      logic        addr_strobe_n;
      logic        data_strobe_n;
      logic        rw_n;
      logic        function_code_2;
      logic        function_code_1;
      logic        function_code_0;
   } cbt_cpu_t;

   typedef enum logic [1:0] {
      CBT_RD_IDLE = 2'b01,
      CBT_RD_RESP = 2'b10
   } cbt_rd_state_t;

endpackage

// [verilog/cbt_watchdog.sv]
/*
 Bus timeout divider: counts slow-clock ticks during a strobed access.
 Assumes tick and ack_rise are one-cycle pulses in the aclk domain.
*/
`timescale 1ns/1ns
`include "cbt_defines.svh"

module cbt_watchdog
   import cbt_pkg::*;
#(
   parameter int DIV = `CBT_WD_DIV
)
(
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       aclk_en,
   // Events
   input  wire logic                       strobe,
   input  wire logic                       tick,
   input  wire logic                       ack_rise,
   // Result
   output logic [$clog2(DIV+1)-1:0]        count_ff,
   output logic                            terminal
);

   localparam int CW = $clog2(DIV+1);

   if (DIV < 2)
   begin : g_bad_div
      $error("cbt_watchdog: DIV must be at least 2");
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_ff <= '0;
      else if (aclk_en)
      begin
         if (ack_rise || !strobe)
            count_ff <= '0;
         else if (tick && !terminal)
            count_ff <= count_ff + CW'(1);
      end
   end

   assign terminal = (count_ff == CW'(DIV));

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_ack_clears;
      aclk_en && ack_rise |=> count_ff == '0;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear watchdog");

   property p_idle_no_count;
      aclk_en && !strobe |=> count_ff == '0 && !terminal;
   endproperty
   a_idle_no_count: assert property (p_idle_no_count) else $error("watchdog ran idle");

endmodule // cbt_watchdog
